/* File: krltb_checker.sv */
// Purpose: port assertions of the error-window and local coefficient block
// Assumes: one clock, synchronous active-high reset
// Notes: bound onto krltb_top at the foot of this file
`include "krltb_params.svh"
`default_nettype none
module krltb_checker #(
   parameter int ERR_W = 24
) (
   // clock and reset
   input wire logic             i_clk_sys,
   input wire logic             i_rst,
   // register port
   input wire logic [10:0]      i_addr,
   input wire logic             i_rd_en,
   input wire logic [31:0]      o_rd_data,
   // error window
   input wire logic             i_eq_step_start,
   input wire logic             i_eq_abort,
   input wire logic             o_step_busy,
   input wire logic             o_step_done,
   input wire logic [ERR_W-1:0] o_step_errs,
   // algorithm side
   input wire logic [5:0]       i_alg_coef_request,
   input wire logic             i_alg_ask_initialize,
   input wire logic             i_alg_ask_preset,
   input wire logic [5:0]       i_alg_coef_report,
   input wire logic             i_rx_eq_complete,
   input wire logic             i_rx_needs_adjust,
   // outgoing words
   input wire logic             i_tx_frame_start,
   input wire logic [5:0]       o_local_coef_request,
   input wire logic             o_ask_partner_initialize,
   input wire logic             o_ask_partner_preset,
   input wire logic [5:0]       o_local_coef_report,
   input wire logic             o_local_receiver_trained,
   input wire logic             o_coef_override
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   // the reserved request code never leaves the device
   function automatic logic [5:0] fix6(input logic [5:0] r);
      fix6 = r;
      for (int i = 0; i < 6; i += 2) begin
         if (r[i+:2] == 2'h3) fix6[i+:2] = 2'h0;
      end
   endfunction : fix6

   a_rd_coef_word: assert property (
      i_rd_en && i_addr == `KRLTB_REG_COEF |=> o_rd_data == {17'h0,
      $past(o_local_receiver_trained), $past(o_local_coef_report), $past(o_ask_partner_preset),
      $past(o_ask_partner_initialize), $past(o_local_coef_request)})
      else $error("coefficient readback differs from sent words");
   a_req_from_alg: assert property (
      i_tx_frame_start ##1 !o_coef_override |->
      o_local_coef_request == fix6($past(i_alg_coef_request))
      && o_ask_partner_initialize == $past(i_alg_ask_initialize)
      && o_ask_partner_preset == $past(i_alg_ask_preset))
      else $error("request word differs from algorithm");
   a_rpt_from_alg: assert property (
      i_tx_frame_start |=> o_local_coef_report == $past(i_alg_coef_report))
      else $error("status word differs from algorithm");
   a_ready_level: assert property (
      i_tx_frame_start |=>
      o_local_receiver_trained == $past(i_rx_eq_complete && !i_rx_needs_adjust))
      else $error("receiver ready bit wrong");
   a_words_hold: assert property (
      !i_tx_frame_start |=> $stable({o_local_coef_request, o_ask_partner_initialize,
      o_ask_partner_preset, o_local_coef_report, o_local_receiver_trained}))
      else $error("outgoing words moved between frames");
   a_start_busy: assert property (
      i_eq_step_start && !i_eq_abort |=> o_step_busy && !o_step_done)
      else $error("window not running after start");
   a_done_pulse: assert property (
      o_step_done |-> !o_step_busy ##1 !o_step_done)
      else $error("done is not a single pulse");
   a_errs_hold: assert property (
      !o_step_done |=> o_step_done || $stable(o_step_errs))
      else $error("error total moved without done");
endmodule : krltb_checker

bind krltb_top krltb_checker #(.ERR_W(ERR_W)) u_checker (
   .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_rd_en(i_rd_en),
   .o_rd_data(o_rd_data), .i_eq_step_start(i_eq_step_start), .i_eq_abort(i_eq_abort),
   .o_step_busy(o_step_busy), .o_step_done(o_step_done), .o_step_errs(o_step_errs),
   .i_alg_coef_request(i_alg_coef_request), .i_alg_ask_initialize(i_alg_ask_initialize),
   .i_alg_ask_preset(i_alg_ask_preset), .i_alg_coef_report(i_alg_coef_report),
   .i_rx_eq_complete(i_rx_eq_complete), .i_rx_needs_adjust(i_rx_needs_adjust),
   .i_tx_frame_start(i_tx_frame_start), .o_local_coef_request(o_local_coef_request),
   .o_ask_partner_initialize(o_ask_partner_initialize),
   .o_ask_partner_preset(o_ask_partner_preset), .o_local_coef_report(o_local_coef_report),
   .o_local_receiver_trained(o_local_receiver_trained), .o_coef_override(o_coef_override));
`default_nettype wire

/* File: krltb_params.svh */
// Purpose: constants of the link-training error-window and local-coefficient block
// Assumes: word-addressed register port, one 40 MHz clock
// Notes: every offset, field position and scale, and the window register reset values, live here
`ifndef KRLTB_PARAMS_SVH
`define KRLTB_PARAMS_SVH

// register port
`define KRLTB_ADDR_W         11
`define KRLTB_REG_BER_WIN    11'h4D3
`define KRLTB_REG_COEF       11'h4D4
`define KRLTB_REG_CTRL       11'h4E0
`define KRLTB_REG_RESULT     11'h4E1
`define KRLTB_REG_STEPS      11'h4E2

// window register fields
`define KRLTB_FRM_LSB        0
`define KRLTB_FRM_MSB        9
`define KRLTB_KFRM_LSB       10
`define KRLTB_KFRM_MSB       19
`define KRLTB_MFRM_LSB       20
`define KRLTB_MFRM_MSB       29
`define KRLTB_FRM_RST_SIM    10'h003
`define KRLTB_FRM_RST_HW     10'h000
`define KRLTB_KFRM_RST_SIM   10'h000
`define KRLTB_KFRM_RST_HW    10'h00F
`define KRLTB_MFRM_RST       10'h000
`define KRLTB_K_SCALE        32'h0000_03E8
`define KRLTB_M_SCALE        32'h000F_4240

// coefficient register fields
`define KRLTB_REQ_LSB        0
`define KRLTB_REQ_MSB        5
`define KRLTB_INIT_BIT       6
`define KRLTB_PRESET_BIT     7
`define KRLTB_RPT_LSB        8
`define KRLTB_RPT_MSB        13
`define KRLTB_READY_BIT      14

// control, result and step count register fields
`define KRLTB_CTRL_OVR_BIT   0
`define KRLTB_RES_ERR_MSB    23
`define KRLTB_RES_BUSY_BIT   24
`define KRLTB_RES_DONE_BIT   25
`define KRLTB_STEPS_W        16

`endif

/* File: krltb_partner.sv */
// Purpose: far-end training logic that sends frames and reads our request word
// Assumes: frames come at least GAP cycles apart, sometimes up to three later
// Notes: error lines carry the inverse of the last value between frames
`default_nettype none
module krltb_partner #(
   parameter int GAP = 4
) (
   // clock and reset
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst,
   // frames towards the block
   output logic            o_rx_frame,
   output logic      [7:0] o_rx_frame_errs,
   // frames from the block
   input  wire logic       i_tx_frame_start,
   input  wire logic [7:0] i_tx_word,
   output logic      [7:0] o_seen_word
);
   logic [3:0] gap_ff;
   logic [7:0] lfsr_ff;
   logic       take_ff;
   wire  logic fire = (gap_ff == 4'h0);

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         gap_ff          <= 4'h0;
         lfsr_ff         <= 8'hA5;
         take_ff         <= 1'b0;
         o_rx_frame      <= 1'b0;
         o_rx_frame_errs <= 8'h00;
         o_seen_word     <= 8'h00;
      end else begin
         lfsr_ff         <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
         o_rx_frame      <= fire;
         gap_ff          <= fire ? 4'(GAP - 1) + {2'h0, lfsr_ff[1:0]} : gap_ff - 4'h1;
         o_rx_frame_errs <= fire ? lfsr_ff : ~o_rx_frame_errs;
         take_ff         <= i_tx_frame_start;
         if (take_ff) o_seen_word <= i_tx_word;
      end
   end
endmodule : krltb_partner
`default_nettype wire

/* File: krltb_pkg.sv */
// Purpose: shared types of the link-training error-window block
// Assumes: constants come from krltb_params.svh
// Notes: types only
`default_nettype none
package krltb_pkg;
   // window counter states
   typedef enum logic {
      WIN_IDLE,
      WIN_COUNT
   } krltb_win_state_t;

   // one tap field of the outgoing request word
   typedef enum logic [1:0] {
      REQ_HOLD = 2'h0,
      REQ_INC  = 2'h1,
      REQ_DEC  = 2'h2,
      REQ_RSVD = 2'h3
   } krltb_req_code_t;

   // one tap field of the outgoing status word
   typedef enum logic [1:0] {
      RPT_NOT_UPD = 2'h0,
      RPT_MIN     = 2'h1,
      RPT_UPD     = 2'h2,
      RPT_MAX     = 2'h3
   } krltb_rpt_code_t;
endpackage : krltb_pkg
`default_nettype wire

/* File: krltb_top.sv */
// Purpose: error-window setup and local coefficient words of the link-training unit
// Assumes: all inputs synchronous to i_clk_sys; register port answers reads next cycle
// Notes: outgoing words change only at a transmitted frame boundary
`include "krltb_params.svh"
`default_nettype none
module krltb_top #(
   parameter bit SIM_BUILD = 1'b0,
   parameter int ERR_W     = 24,
   parameter int INC_W     = 8
) (
   // clock and reset
   input  wire logic                      i_clk_sys,
   input  wire logic                      i_rst,
   // register port
   input  wire logic [`KRLTB_ADDR_W-1:0]  i_addr,
   input  wire logic [31:0]               i_wr_data,
   input  wire logic                      i_wr_en,
   input  wire logic                      i_rd_en,
   output logic      [31:0]               o_rd_data,
   // error window, from and to the equalization engine
   input  wire logic                      i_eq_step_start,
   input  wire logic                      i_eq_abort,
   input  wire logic                      i_rx_frame,
   input  wire logic [INC_W-1:0]          i_rx_frame_errs,
   output logic                           o_step_busy,
   output logic                           o_step_done,
   output logic      [ERR_W-1:0]          o_step_errs,
   // local requests and status from the training algorithm
   input  wire logic [5:0]                i_alg_coef_request,
   input  wire logic                      i_alg_ask_initialize,
   input  wire logic                      i_alg_ask_preset,
   input  wire logic [5:0]                i_alg_coef_report,
   input  wire logic                      i_rx_eq_complete,
   input  wire logic                      i_rx_needs_adjust,
   // outgoing training frame words
   input  wire logic                      i_tx_frame_start,
   output logic      [5:0]                o_local_coef_request,
   output logic                           o_ask_partner_initialize,
   output logic                           o_ask_partner_preset,
   output logic      [5:0]                o_local_coef_report,
   output logic                           o_local_receiver_trained,
   // software override state
   output logic                           o_coef_override
);
   // refuse at elaboration rather than silently cut the result register
   if (ERR_W > 24 || ERR_W < 1 || INC_W < 1) begin : g_bad_width
      $error("krltb_top: error width must be 1..24 to fit the result register");
   end

   localparam logic [9:0] FRM_RST  = SIM_BUILD ? `KRLTB_FRM_RST_SIM  : `KRLTB_FRM_RST_HW;
   localparam logic [9:0] KFRM_RST = SIM_BUILD ? `KRLTB_KFRM_RST_SIM : `KRLTB_KFRM_RST_HW;

   // ---------------- register state ----------------
   logic [9:0]                 frm_ff;
   logic [9:0]                 kfrm_ff;
   logic [9:0]                 mfrm_ff;
   logic                       ovr_ff;
   logic [7:0]                 sw_word_ff;
   logic                       done_ff;
   logic [`KRLTB_STEPS_W-1:0]  steps_ff;
   logic [31:0]                rd_ff;

   // ---------------- decode ----------------
   wire logic hit_win    = (i_addr == `KRLTB_REG_BER_WIN);
   wire logic hit_coef   = (i_addr == `KRLTB_REG_COEF);
   wire logic hit_ctrl   = (i_addr == `KRLTB_REG_CTRL);
   wire logic hit_result = (i_addr == `KRLTB_REG_RESULT);
   wire logic hit_steps  = (i_addr == `KRLTB_REG_STEPS);

   wire logic wr_win     = i_wr_en && hit_win;
   wire logic wr_ctrl    = i_wr_en && hit_ctrl;
   // request bits only take a write while software has taken them over
   wire logic wr_coef    = i_wr_en && hit_coef && ovr_ff;
   wire logic clr_done   = i_wr_en && hit_result && i_wr_data[`KRLTB_RES_DONE_BIT];
   wire logic clr_steps  = i_wr_en && hit_steps;

   // ---------------- window length ----------------
   wire logic [31:0] m_part   = {22'h0, mfrm_ff} * `KRLTB_M_SCALE;
   wire logic [31:0] k_part   = {22'h0, kfrm_ff} * `KRLTB_K_SCALE;
   // single-frame count only counts while thousands is zero
   wire logic [31:0] low_part = (kfrm_ff == 10'h000) ? {22'h0, frm_ff} : k_part;
   wire logic [31:0] win_len  = m_part + low_part;

   // ---------------- outgoing word source ----------------
   wire logic [7:0] alg_word = {i_alg_ask_preset, i_alg_ask_initialize, i_alg_coef_request};
   wire logic [7:0] src_word = ovr_ff ? sw_word_ff : alg_word;

   // reserved request code is never put on the wire; it goes out as hold
   logic [5:0] req_clean;
   genvar t;
   generate
      for (t = 0; t < 3; t = t + 1) begin : g_tap
         wire logic [1:0] code = src_word[2*t +: 2];
         assign req_clean[2*t +: 2] =
            (code == krltb_pkg::REQ_RSVD) ? krltb_pkg::REQ_HOLD : code;
      end
   endgenerate

   // receiver ready only when trained and no further adjustment wanted
   wire logic rx_ready = i_rx_eq_complete && !i_rx_needs_adjust;

   // ---------------- read mux ----------------
   wire logic [31:0] rd_win    = {2'h0, mfrm_ff, kfrm_ff, frm_ff};
   wire logic [31:0] rd_coef   = {17'h0, o_local_receiver_trained, o_local_coef_report,
                                  o_ask_partner_preset, o_ask_partner_initialize,
                                  o_local_coef_request};
   wire logic [31:0] rd_ctrl   = {31'h0, ovr_ff};
   wire logic [23:0] err_pad   = 24'(o_step_errs);
   wire logic [31:0] rd_result = {6'h0, done_ff, o_step_busy, err_pad};
   wire logic [31:0] rd_steps  = {{(32-`KRLTB_STEPS_W){1'b0}}, steps_ff};
   wire logic [31:0] rd_mux    = hit_win    ? rd_win    :
                                 hit_coef   ? rd_coef   :
                                 hit_ctrl   ? rd_ctrl   :
                                 hit_result ? rd_result :
                                 hit_steps  ? rd_steps  : 32'h0000_0000;

   // ---------------- window register ----------------
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         frm_ff  <= FRM_RST;
         kfrm_ff <= KFRM_RST;
         mfrm_ff <= `KRLTB_MFRM_RST;
      end else if (wr_win) begin
         // a count of 2 frames is about a thousand bytes, 20 about ten thousand
         frm_ff  <= i_wr_data[`KRLTB_FRM_MSB:`KRLTB_FRM_LSB];
         kfrm_ff <= i_wr_data[`KRLTB_KFRM_MSB:`KRLTB_KFRM_LSB];
         mfrm_ff <= i_wr_data[`KRLTB_MFRM_MSB:`KRLTB_MFRM_LSB];
      end
   end

   // ---------------- control and override word ----------------
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         ovr_ff     <= 1'b0;
         sw_word_ff <= 8'h00;
      end else begin
         if (wr_ctrl) ovr_ff <= i_wr_data[`KRLTB_CTRL_OVR_BIT];
         if (wr_coef) sw_word_ff <= i_wr_data[`KRLTB_PRESET_BIT:`KRLTB_REQ_LSB];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) o_coef_override <= 1'b0;
      else       o_coef_override <= ovr_ff;
   end

   // ---------------- outgoing training frame words ----------------
   // loaded only at a frame boundary so one frame never carries half-old fields
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         o_local_coef_request     <= 6'h00;
         o_ask_partner_initialize <= 1'b0;
         o_ask_partner_preset     <= 1'b0;
         o_local_coef_report      <= 6'h00;
         o_local_receiver_trained <= 1'b0;
      end else if (i_tx_frame_start) begin
         o_local_coef_request     <= req_clean;
         o_ask_partner_initialize <= src_word[`KRLTB_INIT_BIT];
         o_ask_partner_preset     <= src_word[`KRLTB_PRESET_BIT];
         o_local_coef_report      <= i_alg_coef_report;
         o_local_receiver_trained <= rx_ready;
      end
   end

   // ---------------- error window ----------------
   krltb_win_cnt #(
      .CNT_W (32),
      .ERR_W (ERR_W),
      .INC_W (INC_W)
   ) u_win (
      .i_clk_sys   (i_clk_sys),
      .i_rst       (i_rst),
      .i_start     (i_eq_step_start),
      .i_abort     (i_eq_abort),
      .i_limit     (win_len),
      .i_frame     (i_rx_frame),
      .i_errs      (i_rx_frame_errs),
      .o_busy      (o_step_busy),
      .o_done      (o_step_done),
      .o_err_total (o_step_errs)
   );

   // completion flag and step count; a finishing window beats a clear
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         done_ff  <= 1'b0;
         steps_ff <= '0;
      end else begin
         if (o_step_done)   done_ff <= 1'b1;
         else if (clr_done) done_ff <= 1'b0;
         if (o_step_done)    steps_ff <= steps_ff + `KRLTB_STEPS_W'(1);
         else if (clr_steps) steps_ff <= '0;
      end
   end

   // ---------------- read data ----------------
   // data stands only in the cycle after the strobe, zero otherwise
   always_ff @(posedge i_clk_sys) begin
      if (i_rst)        rd_ff <= 32'h0000_0000;
      else if (i_rd_en) rd_ff <= rd_mux;
      else              rd_ff <= 32'h0000_0000;
   end

   assign o_rd_data = rd_ff;
endmodule : krltb_top
`default_nettype wire

/* File: krltb_win_cnt.sv */
// Purpose: counts received training frames and their bit errors over one step window
// Assumes: i_frame is a one-cycle pulse per received frame, i_errs valid beside it
// Notes: the limit is latched at start so register writes cannot stretch a running window
`default_nettype none
module krltb_win_cnt #(
   parameter int CNT_W = 32,
   parameter int ERR_W = 24,
   parameter int INC_W = 8
) (
   // clock and reset
   input  wire logic             i_clk_sys,
   input  wire logic             i_rst,
   // control
   input  wire logic             i_start,
   input  wire logic             i_abort,
   input  wire logic [CNT_W-1:0] i_limit,
   // received frames
   input  wire logic             i_frame,
   input  wire logic [INC_W-1:0] i_errs,
   // result
   output logic                  o_busy,
   output logic                  o_done,
   output logic      [ERR_W-1:0] o_err_total
);
   if (CNT_W < 31 || INC_W > ERR_W) begin : g_bad_width
      $error("krltb_win_cnt: counter widths cannot hold the window");
   end

   krltb_pkg::krltb_win_state_t state_ff, nxt_state;
   logic [CNT_W-1:0] frm_ff;
   logic [CNT_W-1:0] lim_ff;
   logic [ERR_W-1:0] err_ff;

   wire logic [CNT_W-1:0] frm_inc   = frm_ff + CNT_W'(1);
   wire logic [ERR_W:0]   err_sum   = {1'b0, err_ff} + (ERR_W+1)'(i_errs);
   // saturate rather than wrap: a huge window on a bad link must not look clean
   wire logic [ERR_W-1:0] err_next  = err_sum[ERR_W] ? {ERR_W{1'b1}} : err_sum[ERR_W-1:0];
   wire logic             counting  = (state_ff == krltb_pkg::WIN_COUNT);
   wire logic             last_frm  = counting && i_frame && (frm_inc >= lim_ff);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         krltb_pkg::WIN_IDLE:  if (i_start) nxt_state = krltb_pkg::WIN_COUNT;
         krltb_pkg::WIN_COUNT: begin
            if (i_abort || last_frm) nxt_state = krltb_pkg::WIN_IDLE;
            if (i_start) nxt_state = krltb_pkg::WIN_COUNT;
         end
         default:              nxt_state = krltb_pkg::WIN_IDLE;
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_ff    <= krltb_pkg::WIN_IDLE;
         frm_ff      <= '0;
         lim_ff      <= '0;
         err_ff      <= '0;
         o_busy      <= 1'b0;
         o_done      <= 1'b0;
         o_err_total <= '0;
      end else begin
         state_ff <= nxt_state;
         o_busy   <= (nxt_state == krltb_pkg::WIN_COUNT);
         o_done   <= last_frm && !i_start && !i_abort;
         if (i_start) begin
            frm_ff <= '0;
            err_ff <= '0;
            // zero frames would never end; one frame is the shortest window
            lim_ff <= (i_limit == '0) ? CNT_W'(1) : i_limit;
         end else if (counting && i_frame) begin
            frm_ff <= frm_inc;
            err_ff <= err_next;
         end
         if (last_frm && !i_start && !i_abort) o_err_total <= err_next;
      end
   end
endmodule : krltb_win_cnt
`default_nettype wire

/* File: tb.sv */
// Purpose: self-checking bench of the error-window and local coefficient block
// Assumes: simulation reset set, partner model sends the received frames
// Notes: frame counts and error sums are taken from the frame stream itself
`include "krltb_params.svh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0;
   logic        rst, wr_en, rd_en, start, abort, tx_start, rx_frame;
   logic        ask_init, ask_pre, eq_done, needs_adj, busy, done, linit, lpre, ltrained, ovr;
   logic [10:0] addr;
   logic [31:0] wr_data, rd_data, v, r;
   logic [31:0] seed = 32'h0001_86CE;
   logic [5:0]  alg_req, alg_rpt, lreq, lrpt;
   logic [7:0]  rx_errs, seen;
   logic [23:0] step_errs;
   int          errors, tests_run, fcnt, esum;

   always #12.5 clk = ~clk;

   krltb_top #(.SIM_BUILD(1'b1)) dut (
      .i_clk_sys(clk), .i_rst(rst), .i_addr(addr), .i_wr_data(wr_data), .i_wr_en(wr_en),
      .i_rd_en(rd_en), .o_rd_data(rd_data), .i_eq_step_start(start), .i_eq_abort(abort),
      .i_rx_frame(rx_frame), .i_rx_frame_errs(rx_errs), .o_step_busy(busy),
      .o_step_done(done), .o_step_errs(step_errs), .i_alg_coef_request(alg_req),
      .i_alg_ask_initialize(ask_init), .i_alg_ask_preset(ask_pre), .i_alg_coef_report(alg_rpt),
      .i_rx_eq_complete(eq_done), .i_rx_needs_adjust(needs_adj), .i_tx_frame_start(tx_start),
      .o_local_coef_request(lreq), .o_ask_partner_initialize(linit),
      .o_ask_partner_preset(lpre), .o_local_coef_report(lrpt),
      .o_local_receiver_trained(ltrained), .o_coef_override(ovr));

   krltb_partner #(.GAP(4)) u_far (
      .i_clk_sys(clk), .i_rst(rst), .o_rx_frame(rx_frame), .o_rx_frame_errs(rx_errs),
      .i_tx_frame_start(tx_start), .i_tx_word({lpre, linit, lreq}), .o_seen_word(seen));

   always @(posedge clk) begin
      if (busy === 1'b1 && rx_frame === 1'b1) begin
         fcnt++;
         esum += int'(rx_errs);
      end
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   // reserved request code goes out as hold
   function automatic logic [5:0] fix_req(input logic [5:0] q);
      fix_req = q;
      for (int i = 0; i < 6; i += 2) begin
         if (q[i+:2] == 2'h3) fix_req[i+:2] = 2'h0;
      end
   endfunction : fix_req

   task automatic chk(input string name, input logic [31:0] seen_v, input logic [31:0] exp);
      tests_run++;
      if (seen_v !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen_v);
      end
   endtask : chk

   task automatic wr(input logic [10:0] a, input logic [31:0] d);
      @(posedge clk);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge clk);
      wr_en   <= 1'b0;
   endtask : wr

   task automatic rd(input logic [10:0] a, output logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask : rd

   task automatic tx_frame();
      @(posedge clk);
      tx_start <= 1'b1;
      @(posedge clk);
      tx_start <= 1'b0;
      @(posedge clk);
      #1;
   endtask : tx_frame

   // a cut window is aborted after a few frames and must leave no result
   task automatic run_win(input logic [29:0] w, input bit cut);
      int len;
      int k;
      len = (w[19:10] == 10'h000) ? int'(w[9:0]) : int'(w[19:10]) * 1000;
      len += int'(w[29:20]) * 1000000;
      if (len == 0) len = 1;
      wr(`KRLTB_REG_BER_WIN, {2'h0, w});
      @(posedge clk iff rx_frame === 1'b1);
      start <= 1'b1;
      fcnt = 0;
      esum = 0;
      @(posedge clk);
      start <= 1'b0;
      if (cut) begin
         v = {8'h00, step_errs};
         repeat (10) @(posedge clk);
         abort <= 1'b1;
         @(posedge clk);
         abort <= 1'b0;
         repeat (2) @(posedge clk);
         #1 chk("abort_busy", {busy, step_errs}, {1'b0, v[23:0]});
      end else begin
         k = 0;
         while (done !== 1'b1 && k < 20000) begin
            @(posedge clk);
            #1 k++;
         end
         chk("win_frames", fcnt, len);
         chk("win_errs", step_errs, esum);
      end
      $display("window test %h done", w);
   endtask : run_win

   task automatic test_done();
      $display("%0d checks, %0d mismatches", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done

   initial begin
      #1500000;
      errors++;
      test_done();
   end

   initial begin
      {wr_en, rd_en, start, abort, tx_start, ask_init, ask_pre, eq_done, needs_adj} = '0;
      {addr, wr_data, alg_req, alg_rpt} = '0;
      rst = 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(`KRLTB_REG_BER_WIN, v);
      chk("win_reset", v, 32'h0000_0003);
      r = xs();
      wr(`KRLTB_REG_BER_WIN, r);
      rd(`KRLTB_REG_BER_WIN, v);
      chk("win_rw", v, r & 32'h3FFF_FFFF);
      rd(11'h7FF, v);
      chk("unmapped", v, 32'h0);
      $display("register test done");
      run_win(30'h0000_0002, 1'b0);
      run_win(30'h0000_0000, 1'b0);
      run_win(30'h0000_03FF, 1'b0);
      run_win({10'h000, 10'h001, 10'h005}, 1'b0);
      run_win(30'(xs() & 32'h0000_003F), 1'b0);
      run_win(30'h0000_03FF, 1'b1);
      rd(`KRLTB_REG_STEPS, v);
      chk("steps", v, 32'h0000_0005);
      rd(`KRLTB_REG_RESULT, v);
      chk("result", v, {6'h00, 2'h2, step_errs});
      for (int i = 0; i < 12; i++) begin
         r = xs();
         alg_req <= (i < 4) ? {3{2'(i)}} : r[5:0];
         {needs_adj, eq_done, ask_pre, ask_init, alg_rpt} <= r[15:6];
         tx_frame();
         v = {17'h0, eq_done & ~needs_adj, alg_rpt, ask_pre, ask_init, fix_req(alg_req)};
         chk("words", {17'h0, ltrained, lrpt, lpre, linit, lreq}, v);
         chk("far_end", seen, v[7:0]);
         rd(`KRLTB_REG_COEF, r);
         chk("coef_rd", r, v);
      end
      wr(`KRLTB_REG_COEF, 32'h0000_00FF);
      tx_frame();
      chk("ro_req", lreq, fix_req(alg_req));
      wr(`KRLTB_REG_CTRL, 32'h0000_0001);
      tx_frame();
      chk("ovr_flag", ovr, 1'b1);
      chk("ovr_keep", {lpre, linit, lreq}, 8'h00);
      wr(`KRLTB_REG_COEF, 32'h0000_7F9B);
      tx_frame();
      chk("ovr_word", {lrpt, lpre, linit, lreq}, {alg_rpt, 2'h2, 6'h18});
      wr(`KRLTB_REG_CTRL, 32'h0000_0000);
      $display("coefficient test done");
      test_done();
   end
endmodule : tb
`default_nettype wire
